// ==== design/tcw_capture_channel.sv ====
// Timer channel used as pulse interval or level width capture unit
//
// Overview of operation
// - Interval mode start clears counter to zero, then counts up each count tick.
// - Interval edge copies counter to data, clears counter, raises interrupt.
// - Every capture writes wrap flag: one if counter wrapped, else zero.
// - Two or more wraps still only set the wrap flag to one.
// - Interval mode: start write while enabled acts as a capture trigger.
// - Edge field: 00B falling, 01B rising, 10B both; 11B unused here.
// - Start interrupt setting chooses interrupt at counting start.
// - Op clock field 00B clock0, 10B clock1, 01B/11B clocks 2/3.
// - Pin sampled on selected operation clock; one tick of error.
// - Interval equals tick period times (10000H*flag + capture + 1).
// - Width mode start write sets enable and waits for start edge.
// - Width: start edge counts from zero; opposite edge captures, interrupts.
// - After width capture counter holds capture plus one; wait again.
// - Width edge field 10B low width, 11B high width.
// - Width mode start write ignored while enable already set.
// - Input switch bit 1 routes serial receive pin 2 to the input.
//
// The placing of the registers and the Wishbone register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module tcw_capture_channel #(
  parameter bit HAS_CLK23 = 1'b1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [4:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Prescaled clock ticks from the unit prescaler
  input wire logic [3:0] prescaled_clock_i,
  // Measured pins
  input wire logic capture_input_pin_i,
  input wire logic serial_receive_pin_2_i,
  // Channel event
  output logic channel_interrupt_o
);
  tcw_pkg::tcw_mode_t mode_r, mode_nxt;
  tcw_pkg::tcw_state_t state_r, state_nxt;
  logic [15:0] count_r, count_nxt;
  logic [15:0] data_r, data_nxt;
  logic wrap_flag_r, wrap_flag_nxt;
  logic wrap_seen_r, wrap_seen_nxt;
  logic switch_r, switch_nxt;
  logic irq_r, irq_nxt;
  logic ack_r, ack_nxt;
  logic [31:0] rdat_r, rdat_nxt;
  logic op_tick;
  logic pin_sel;
  logic pin_rise;
  logic pin_fall;
  logic count_tick;
  logic wb_req;
  logic start_wr;
  logic stop_wr;
  logic enable;
  logic is_width;
  logic iv_edge;
  logic w_start_edge;
  logic w_cap_edge;
  logic capture;
  logic [16:0] inc;

  // ==========================================================
  // Operation clock selection; clocks 2 and 3 only where fitted
  always_comb begin
    op_tick = 1'b0;
    case (mode_r.op_clk_sel)
      tcw_pkg::OPCLK_0: op_tick = prescaled_clock_i[0];
      tcw_pkg::OPCLK_1: op_tick = prescaled_clock_i[1];
      tcw_pkg::OPCLK_2: op_tick = HAS_CLK23 & prescaled_clock_i[2];
      default: op_tick = HAS_CLK23 & prescaled_clock_i[3];
    endcase
  end

  // Input routing; the mux sits ahead of the synchroniser
  assign pin_sel = switch_r ? serial_receive_pin_2_i :
      capture_input_pin_i;

  // Pin sampled only on the operation clock tick
  tcw_pin_sampler u_sampler (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(pin_sel),
    .sample_i(op_tick),
    .rise_o(pin_rise),
    .fall_o(pin_fall)
  );

  // ==========================================================
  // Trigger decode
  assign wb_req = cyc_i & stb_i & ~ack_r;
  assign start_wr = wb_req & we_i & sel_i[0] & (adr_i == tcw_pkg::ADR_START)
      & dat_i[tcw_pkg::TRIG_BIT];
  assign stop_wr = wb_req & we_i & sel_i[0] & (adr_i == tcw_pkg::ADR_STOP)
      & dat_i[tcw_pkg::TRIG_BIT];
  assign enable = (state_r != tcw_pkg::ST_IDLE);
  assign is_width = (mode_r.op_mode == tcw_pkg::OPM_WIDTH);
  // Count select of one counts every pin edge, rising or falling, instead of clock ticks
  assign count_tick = mode_r.count_clock_select ? (pin_rise | pin_fall) :
      op_tick;

  // Valid edge for interval mode; 11B gives no edge at all
  always_comb begin
    iv_edge = 1'b0;
    if (mode_r.trigger_source_select == tcw_pkg::TRIG_PIN_EDGE) begin
      case (mode_r.input_edge_select)
        tcw_pkg::EDGE_FALL: iv_edge = pin_fall;
        tcw_pkg::EDGE_RISE: iv_edge = pin_rise;
        tcw_pkg::EDGE_BOTH: iv_edge = pin_rise | pin_fall;
        default: iv_edge = 1'b0;
      endcase
    end
  end

  // Width mode start and capture edges are of opposite polarity
  always_comb begin
    w_start_edge = 1'b0;
    w_cap_edge = 1'b0;
    if (mode_r.input_edge_select == tcw_pkg::EDGE_LOW_W) begin
      w_start_edge = pin_fall;
      w_cap_edge = pin_rise;
    end else if (mode_r.input_edge_select == tcw_pkg::EDGE_HIGH_W) begin
      w_start_edge = pin_rise;
      w_cap_edge = pin_fall;
    end
  end

  // ==========================================================
  // Measurement engine
  always_comb begin
    state_nxt = state_r;
    count_nxt = count_r;
    data_nxt = data_r;
    wrap_flag_nxt = wrap_flag_r;
    wrap_seen_nxt = wrap_seen_r;
    irq_nxt = 1'b0;
    capture = 1'b0;
    inc = {1'b0, count_r} + 17'h00001;
    if (count_tick) begin
      count_nxt = inc[15:0];
      wrap_seen_nxt = wrap_seen_r | inc[16];
    end
    case (state_r)
      tcw_pkg::ST_IDLE: begin
        count_nxt = count_r;
        wrap_seen_nxt = wrap_seen_r;
        if (start_wr && !is_width) begin
          state_nxt = tcw_pkg::ST_COUNT;
          count_nxt = tcw_pkg::COUNT_RST;
          wrap_seen_nxt = 1'b0;
          irq_nxt = mode_r.start_interrupt_setting;
        end else if (start_wr) begin
          state_nxt = tcw_pkg::ST_WAIT_START;
        end
      end
      tcw_pkg::ST_COUNT: begin
        // A capture in a tick cycle drops that tick; the new period
        // starts from zero
        if (iv_edge || start_wr) begin
          capture = 1'b1;
          data_nxt = count_r;
          count_nxt = tcw_pkg::COUNT_RST;
          wrap_flag_nxt = wrap_seen_r;
          wrap_seen_nxt = 1'b0;
          irq_nxt = 1'b1;
        end
      end
      tcw_pkg::ST_WAIT_START: begin
        // Counter holds while waiting; a start write here is ignored
        count_nxt = count_r;
        wrap_seen_nxt = wrap_seen_r;
        if (w_start_edge) begin
          state_nxt = tcw_pkg::ST_MEASURE;
          count_nxt = tcw_pkg::COUNT_RST;
          wrap_seen_nxt = 1'b0;
          irq_nxt = mode_r.start_interrupt_setting;
        end
      end
      default: begin
        if (w_cap_edge) begin
          capture = 1'b1;
          state_nxt = tcw_pkg::ST_WAIT_START;
          data_nxt = count_r;
          count_nxt = inc[15:0];
          wrap_flag_nxt = wrap_seen_r;
          wrap_seen_nxt = 1'b0;
          irq_nxt = 1'b1;
        end
      end
    endcase
    if (stop_wr) begin
      state_nxt = tcw_pkg::ST_IDLE;
    end
  end

  // Engine registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= tcw_pkg::ST_IDLE;
      count_r <= tcw_pkg::COUNT_RST;
      data_r <= tcw_pkg::DATA_RST;
      wrap_flag_r <= 1'b0;
      wrap_seen_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      count_r <= count_nxt;
      data_r <= data_nxt;
      wrap_flag_r <= wrap_flag_nxt;
      wrap_seen_r <= wrap_seen_nxt;
      irq_r <= irq_nxt;
    end
  end

  // ==========================================================
  // Wishbone slave: one wait state, ack for one cycle, unmapped reads 0
  always_comb begin
    mode_nxt = mode_r;
    switch_nxt = switch_r;
    ack_nxt = wb_req;
    rdat_nxt = 32'h0000_0000;
    if (wb_req && we_i) begin
      if (adr_i == tcw_pkg::ADR_MODE) begin
        if (sel_i[0]) begin
          mode_nxt[7:0] = dat_i[7:0];
        end
        if (sel_i[1]) begin
          mode_nxt[15:8] = dat_i[15:8];
        end
      end else if (adr_i == tcw_pkg::ADR_SWITCH && sel_i[0]) begin
        switch_nxt = dat_i[tcw_pkg::SWITCH_BIT];
      end
    end else if (wb_req) begin
      if (adr_i == tcw_pkg::ADR_MODE) begin
        rdat_nxt = {16'h0000, mode_r};
      end else if (adr_i == tcw_pkg::ADR_ENABLE) begin
        rdat_nxt = {31'h0000_0000, enable};
      end else if (adr_i == tcw_pkg::ADR_COUNT) begin
        rdat_nxt = {16'h0000, count_r};
      end else if (adr_i == tcw_pkg::ADR_DATA) begin
        rdat_nxt = {16'h0000, data_r};
      end else if (adr_i == tcw_pkg::ADR_STATUS) begin
        rdat_nxt = {31'h0000_0000, wrap_flag_r};
      end else if (adr_i == tcw_pkg::ADR_SWITCH) begin
        rdat_nxt = {30'h0000_0000, switch_r, 1'b0};
      end
    end
  end

  // Bus registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_r <= tcw_pkg::MODE_RST;
      switch_r <= 1'b0;
      ack_r <= 1'b0;
      rdat_r <= 32'h0000_0000;
    end else begin
      mode_r <= mode_nxt;
      switch_r <= switch_nxt;
      ack_r <= ack_nxt;
      rdat_r <= rdat_nxt;
    end
  end

  assign dat_o = rdat_r;
  assign ack_o = ack_r;
  assign channel_interrupt_o = irq_r;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_start_zero: assert property (state_r == tcw_pkg::ST_IDLE &&
      start_wr && !is_width && !stop_wr |=> count_r == 16'h0000 && enable)
    else $error("interval start did not clear counter");
  a_capture_copy: assert property (capture && !stop_wr &&
      state_r == tcw_pkg::ST_COUNT |=> data_r == $past(count_r) &&
      count_r == 16'h0000)
    else $error("interval capture did not copy and clear");
  a_capture_irq: assert property (capture |=> channel_interrupt_o
      ##1 !channel_interrupt_o || $past(irq_nxt))
    else $error("capture without interrupt");
  a_wrap_update: assert property (capture |=>
      wrap_flag_r == $past(wrap_seen_r))
    else $error("wrap flag not updated at capture");
  a_wrap_sticky: assert property (wrap_seen_r && !capture &&
      state_r != tcw_pkg::ST_IDLE && state_r != tcw_pkg::ST_WAIT_START
      |=> wrap_seen_r)
    else $error("recorded wrap lost before capture");
  a_width_hold: assert property (capture && !stop_wr &&
      state_r == tcw_pkg::ST_MEASURE |=> count_r == data_r + 16'h0001 &&
      state_r == tcw_pkg::ST_WAIT_START ##1 count_r == $past(count_r) ||
      state_r != tcw_pkg::ST_WAIT_START)
    else $error("width counter not held at capture plus one");
  // A slow operation clock may leave the count unchanged; only a tick moves it
  a_width_no_restart: assert property (start_wr && !stop_wr &&
      state_r == tcw_pkg::ST_MEASURE && !w_cap_edge |=>
      state_r == tcw_pkg::ST_MEASURE &&
      count_r == $past(count_r) + {15'h0000, $past(count_tick)})
    else $error("start write restarted an enabled width channel");
  a_start_irq: assert property (w_start_edge && !stop_wr &&
      state_r == tcw_pkg::ST_WAIT_START |=> channel_interrupt_o ==
      $past(mode_r.start_interrupt_setting))
    else $error("start interrupt setting not honoured");
  a_bus_ack: assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1
      !ack_o)
    else $error("bus ack not a single cycle");

  c_interval: cover property (capture && state_r == tcw_pkg::ST_COUNT);
  c_width: cover property (capture && state_r == tcw_pkg::ST_MEASURE);
  c_wrap: cover property (capture && wrap_seen_r);
endmodule
`default_nettype wire

// ==== design/tcw_pkg.sv ====
// Constants and types shared by the capture/width measurement channel
package tcw_pkg;
  // ==========================================================
  // Register byte offsets on the Wishbone slave
  localparam logic [4:0] ADR_MODE = 5'h00;
  localparam logic [4:0] ADR_START = 5'h04;
  localparam logic [4:0] ADR_STOP = 5'h08;
  localparam logic [4:0] ADR_ENABLE = 5'h0C;
  localparam logic [4:0] ADR_COUNT = 5'h10;
  localparam logic [4:0] ADR_DATA = 5'h14;
  localparam logic [4:0] ADR_STATUS = 5'h18;
  localparam logic [4:0] ADR_SWITCH = 5'h1C;

  // ==========================================================
  // Field positions and reset values
  localparam int WRAP_BIT = 0;
  localparam int SWITCH_BIT = 1;
  localparam int TRIG_BIT = 0;
  localparam logic [15:0] MODE_RST = 16'h0000;
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [15:0] DATA_RST = 16'h0000;
  // Added to the count once per recorded wrap when converting to time
  localparam logic [16:0] WRAP_WEIGHT = 17'h10000;

  // ==========================================================
  // Field encodings
  localparam logic [2:0] OPM_INTERVAL = 3'h2;
  localparam logic [2:0] OPM_WIDTH = 3'h6;
  localparam logic [2:0] TRIG_PIN_EDGE = 3'h1;
  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h2;
  localparam logic [1:0] EDGE_LOW_W = 2'h2;
  localparam logic [1:0] EDGE_HIGH_W = 2'h3;
  localparam logic [1:0] OPCLK_0 = 2'h0;
  localparam logic [1:0] OPCLK_2 = 2'h1;
  localparam logic [1:0] OPCLK_1 = 2'h2;
  localparam logic [1:0] OPCLK_3 = 2'h3;

  // Channel mode register layout
  typedef struct packed {
    logic [1:0] op_clk_sel;
    logic rsv13;
    logic count_clock_select;
    logic pair_split_sel;
    logic [2:0] trigger_source_select;
    logic [1:0] input_edge_select;
    logic [1:0] rsv54;
    logic [2:0] op_mode;
    logic start_interrupt_setting;
  } tcw_mode_t;

  // Channel state
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_COUNT,
    ST_WAIT_START,
    ST_MEASURE
  } tcw_state_t;
endpackage

// ==== design/tcw_pin_sampler.sv ====
// Three-stage pin synchroniser with sampling on the operation clock tick
`timescale 1ns/1ps
`default_nettype none
module tcw_pin_sampler (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Pin and sample strobe
  input wire logic pin_i,
  input wire logic sample_i,
  // Detected edges, one-cycle pulses
  output logic rise_o,
  output logic fall_o
);
  logic [2:0] sync_r;
  logic [2:0] sync_nxt;
  logic level_r;
  logic level_nxt;
  logic rise_r;
  logic rise_nxt;
  logic fall_r;
  logic fall_nxt;

  // ==========================================================
  // A level counts only once stages two and three agree, and only on a
  // tick of the operation clock, so width carries up to one tick of error
  always_comb begin
    sync_nxt = {sync_r[1:0], pin_i};
    level_nxt = level_r;
    rise_nxt = 1'b0;
    fall_nxt = 1'b0;
    if (sample_i && (sync_r[1] == sync_r[2]) && (sync_r[2] != level_r)) begin
      level_nxt = sync_r[2];
      rise_nxt = sync_r[2];
      fall_nxt = ~sync_r[2];
    end
  end

  // Registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_r <= 3'h0;
      level_r <= 1'b0;
      rise_r <= 1'b0;
      fall_r <= 1'b0;
    end else begin
      sync_r <= sync_nxt;
      level_r <= level_nxt;
      rise_r <= rise_nxt;
      fall_r <= fall_nxt;
    end
  end

  assign rise_o = rise_r;
  assign fall_o = fall_r;
endmodule
`default_nettype wire

// ==== tb/tcw_pin_source.sv ====
// Pulse source model driving the measured pin of the capture channel
`timescale 1ns/1ps
`default_nettype none
module tcw_pin_source (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Waveform control
  input wire logic run_i,
  input wire logic [17:0] hi_len_i,
  input wire logic [17:0] lo_len_i,
  // Driven pin
  output logic pin_o
);
  logic [17:0] cnt_r;

  // ==========================================================
  // Waveform: idles low, opens with a high phase so a rise comes first
  always_ff @(posedge clk_i) begin
    if (rst_i || !run_i) begin
      pin_o <= 1'b0;
      cnt_r <= 18'h00000;
    end else if (cnt_r == 18'h00000) begin
      pin_o <= !pin_o;
      cnt_r <= (pin_o ? lo_len_i : hi_len_i) - 18'h00001;
    end else begin
      cnt_r <= cnt_r - 18'h00001;
    end
  end
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench for the capture and width measurement channel
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk_i, rst_i, cyc, stb, we, ack, irq, src_pin, use_ser, run;
  logic [4:0] adr;
  logic [3:0] sel, presc;
  logic [31:0] dat_w, dat_r;
  logic [2:0] tick_cnt = 3'h0;
  logic [17:0] hi_len, lo_len;
  int irq_cnt, base, failures, comparisons;

  // ==========================================================
  // Clock, prescaler ticks every 1, 2, 4 and 8 cycles, interrupt tally
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  assign presc = {tick_cnt == 3'h7, tick_cnt[1:0] == 2'h3, tick_cnt[0], 1'b1};
  always @(posedge clk_i) begin
    tick_cnt <= tick_cnt + 3'h1;
    if (irq === 1'b1) irq_cnt <= irq_cnt + 1;
  end

  // Design and pin source; the unused pin idles at its quiet level
  tcw_capture_channel dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(dat_w), .dat_o(dat_r), .ack_o(ack),
    .prescaled_clock_i(presc),
    .capture_input_pin_i(use_ser ? 1'b0 : src_pin),
    .serial_receive_pin_2_i(use_ser ? src_pin : 1'b1),
    .channel_interrupt_o(irq)
  );
  tcw_pin_source src_u (
    .clk_i(clk_i), .rst_i(rst_i), .run_i(run), .hi_len_i(hi_len),
    .lo_len_i(lo_len), .pin_o(src_pin)
  );

  // ==========================================================
  // Comparisons and verdict
  task automatic check_val(input string nm, input logic [31:0] e,
                           input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic check_rng(input string nm, input logic [31:0] lo,
                           input logic [31:0] hi, input logic [31:0] g);
    comparisons++;
    if ((g >= lo && g <= hi) !== 1'b1) begin
      failures++;
      $display("MISMATCH %s expected %0h..%0h seen %0h", nm, lo, hi, g);
    end
  endtask
  task automatic print_verdict();
    $display("TB: failures=%0d comparisons=%0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // ==========================================================
  // Wishbone classic master: hold until ack, release at that edge
  task automatic wb(input logic w, input logic [4:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_w <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    check_val("bus_ack", 32'h1, {31'h0, ack});
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [4:0] a, output logic [31:0] q);
    wb(1'b0, a, 32'h0, q);
  endtask

  // Mode word; pairing bit and unused fields left at zero
  function automatic logic [31:0] mk_mode(input logic [1:0] ck,
    input logic [1:0] ed, input logic [2:0] om, input logic si);
    tcw_pkg::tcw_mode_t m;
    m = '0;
    m.op_clk_sel = ck;
    m.pair_split_sel = 1'b0;
    m.trigger_source_select = tcw_pkg::TRIG_PIN_EDGE;
    m.input_edge_select = ed;
    m.op_mode = om;
    m.start_interrupt_setting = si;
    return {16'h0000, m};
  endfunction

  // Set mode, start the channel, judge the start interrupt, launch pin
  task automatic arm(input logic [31:0] md, input logic go);
    wr(tcw_pkg::ADR_MODE, md);
    base = irq_cnt;
    wr(tcw_pkg::ADR_START, 32'h1);
    repeat (2) @(posedge clk_i);
    check_val("start_irq", base + md[0], irq_cnt);
    base = irq_cnt;
    run <= go;
  endtask
  task automatic wait_irq(input int target);
    int n;
    n = 0;
    while (irq_cnt < target && n < 100000) begin
      @(posedge clk_i);
      n++;
    end
    check_val("irq_seen", 32'h1, {31'h0, irq_cnt >= target});
  endtask
  task automatic halt();
    wr(tcw_pkg::ADR_STOP, 32'h1);
    run <= 1'b0;
    repeat (40) @(posedge clk_i);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    logic [4:0] al [6] = '{tcw_pkg::ADR_MODE, tcw_pkg::ADR_COUNT,
      tcw_pkg::ADR_DATA, tcw_pkg::ADR_STATUS, tcw_pkg::ADR_ENABLE, 5'h01};
    logic [31:0] q;
    foreach (al[i]) begin
      rd(al[i], q);
      check_val("reset_reg", 32'h0, q);
    end
  endtask
  // Each edge code, including the one that must give no capture
  task automatic t_interval();
    logic [31:0] q;
    hi_len <= 18'h10;
    lo_len <= 18'h10;
    for (int e = 0; e < 4; e++) begin
      arm(mk_mode(tcw_pkg::OPCLK_0, 2'(e), tcw_pkg::OPM_INTERVAL, 1'b0), 1);
      if (e == 3) begin
        repeat (100) @(posedge clk_i);
        check_val("no_edge", base, irq_cnt);
      end else begin
        wait_irq(base + 2);
        rd(tcw_pkg::ADR_DATA, q);
        check_val("interval", (e == 2) ? 32'hF : 32'h1F, q);
        rd(tcw_pkg::ADR_STATUS, q);
        check_val("no_wrap", 32'h0, q);
      end
      halt();
    end
    // Count select of one counts pin edges: one fall between two rises
    arm(mk_mode(tcw_pkg::OPCLK_0, tcw_pkg::EDGE_RISE, tcw_pkg::OPM_INTERVAL,
                1'b0) | 32'h0000_1000, 1);
    wait_irq(base + 2);
    rd(tcw_pkg::ADR_DATA, q);
    check_val("edge_count", 32'h1, q);
    halt();
    // Trigger source other than pin edges: the pin gives no capture
    arm(mk_mode(tcw_pkg::OPCLK_0, tcw_pkg::EDGE_RISE, tcw_pkg::OPM_INTERVAL,
                1'b0) & 32'h0000_F8FF, 1);
    repeat (100) @(posedge clk_i);
    check_val("no_trigger", base, irq_cnt);
    halt();
  endtask
  task automatic t_soft();
    logic [31:0] q;
    arm(mk_mode(tcw_pkg::OPCLK_0, tcw_pkg::EDGE_RISE,
                tcw_pkg::OPM_INTERVAL, 1'b1), 0);
    rd(tcw_pkg::ADR_COUNT, q);
    check_rng("count_up", 32'h2, 32'h10, q);
    wr(tcw_pkg::ADR_START, 32'h1);
    repeat (2) @(posedge clk_i);
    check_val("soft_irq", base + 1, irq_cnt);
    rd(tcw_pkg::ADR_DATA, q);
    check_rng("soft_data", 32'h4, 32'h20, q);
    halt();
  endtask
  // Slower ticks give fewer counts, within two ticks below the ideal
  task automatic t_opclk();
    logic [1:0] ck [4] = '{tcw_pkg::OPCLK_0, tcw_pkg::OPCLK_1,
      tcw_pkg::OPCLK_2, tcw_pkg::OPCLK_3};
    logic [31:0] q;
    hi_len <= 18'h20;
    lo_len <= 18'h20;
    for (int i = 0; i < 4; i++) begin
      arm(mk_mode(ck[i], tcw_pkg::EDGE_RISE, tcw_pkg::OPM_INTERVAL, 1'b0), 1);
      wait_irq(base + 2);
      rd(tcw_pkg::ADR_DATA, q);
      check_rng("op_clock", (64 >> i) - 2, (64 >> i), q);
      halt();
    end
  endtask
  task automatic t_width();
    logic [31:0] q, c;
    hi_len <= 18'h0C;
    lo_len <= 18'h14;
    for (int h = 0; h < 3; h++) begin
      if (h == 2) wr(tcw_pkg::ADR_SWITCH, 32'h2);
      use_ser <= (h == 2);
      arm(mk_mode(tcw_pkg::OPCLK_0, h ? tcw_pkg::EDGE_HIGH_W :
                  tcw_pkg::EDGE_LOW_W, tcw_pkg::OPM_WIDTH, 1'b0), 1);
      rd(tcw_pkg::ADR_ENABLE, q);
      check_val("enable", 32'h1, q);
      wait_irq(base + 1);
      rd(tcw_pkg::ADR_DATA, q);
      check_rng("width", h ? 32'hA : 32'h12, h ? 32'hC : 32'h14, q);
      rd(tcw_pkg::ADR_COUNT, c);
      check_val("count_hold", q + 32'h1, c);
      // Land the start write mid-measurement, where it must be ignored
      repeat (14) @(posedge clk_i);
      wr(tcw_pkg::ADR_START, 32'h1);
      wait_irq(base + 2);
      rd(tcw_pkg::ADR_DATA, c);
      check_val("width_again", q, c);
      halt();
    end
    // Pin 2 no longer routed: the static capture pin gives nothing
    wr(tcw_pkg::ADR_SWITCH, 32'h0);
    arm(mk_mode(tcw_pkg::OPCLK_0, tcw_pkg::EDGE_HIGH_W,
                tcw_pkg::OPM_WIDTH, 1'b0), 1);
    repeat (100) @(posedge clk_i);
    check_val("switch_off", base, irq_cnt);
    halt();
    use_ser <= 1'b0;
  endtask
  // One 70000-cycle period wraps once; a quick soft capture clears it
  task automatic t_wrap();
    logic [31:0] q;
    hi_len <= 18'h01388;
    lo_len <= 18'h0FDE8;
    arm(mk_mode(tcw_pkg::OPCLK_0, tcw_pkg::EDGE_RISE,
                tcw_pkg::OPM_INTERVAL, 1'b0), 1);
    wait_irq(base + 2);
    rd(tcw_pkg::ADR_DATA, q);
    check_val("wrap_data", 32'h116F, q);
    rd(tcw_pkg::ADR_STATUS, q);
    check_val("wrap_set", 32'h1, q);
    wr(tcw_pkg::ADR_START, 32'h1);
    wait_irq(base + 3);
    rd(tcw_pkg::ADR_STATUS, q);
    check_val("wrap_clear", 32'h0, q);
    halt();
  endtask

  // ==========================================================
  // Main sequence and watchdog
  initial begin
    {cyc, stb, we, run, use_ser} = 5'h00;
    {adr, dat_w} = '0;
    sel = 4'hF;
    {hi_len, lo_len} = '0;
    rst_i = 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    t_reset();
    t_interval();
    t_soft();
    t_opclk();
    t_width();
    t_wrap();
    print_verdict();
  end
  initial begin
    repeat (90000) @(posedge clk_i);
    failures++;
    print_verdict();
  end
endmodule
`default_nettype wire
